// file: hw/crx_params.svh
// Constants for the camera lane receiver and packet parser
`ifndef CRX_PARAMS_SVH
`define CRX_PARAMS_SVH
`define CRX_LP_STOP 2'h3
`define CRX_LP_HS_RQ 2'h1
`define CRX_LP_BRIDGE 2'h0
`define CRX_SHORT_DT_MAX 6'h0f
`define CRX_VC_MSB 7
`define CRX_VC_LSB 6
`define CRX_DT_MSB 5
`define CRX_WC_MSB 23
`define CRX_WC_LSB 8
`define CRX_ECC_BITS 6
`define CRX_HDR_BITS 24
`define CRX_HDR_LAST 2'h3
`define CRX_CRC_SEED 16'hffff
`define CRX_CRC_POLY 16'h8408
`define CRX_ECC_M0 24'hf1_2cb7
`define CRX_ECC_M1 24'hf2_555b
`define CRX_ECC_M2 24'h74_9a6d
`define CRX_ECC_M3 24'hb8_e38e
`define CRX_ECC_M4 24'hdf_03f0
`define CRX_ECC_M5 24'hef_fc00
`define CRX_ERR_CNT_MAX 8'hff
`endif

// file: hw/crx_pkg.sv
// Types for the camera lane receiver and packet parser
package crx_pkg;
  typedef enum logic [1:0] {LN_INIT, LN_STOP, LN_HS_RQ, LN_HS} crx_lane_e;
  typedef enum logic [2:0] {PS_HDR, PS_DATA, PS_CRC_LO, PS_CRC_HI, PS_SKIP} crx_parse_e;
endpackage : crx_pkg

// file: hw/crx_lane_if.sv
// Signals between the receiver core and one lane tracker
`timescale 1ns/1ns
interface crx_lane_if;
  logic [1:0] lp_pin;
  logic [7:0] hs_byte;
  logic hs_valid;
  logic force_hs;
  logic term_en;
  logic [7:0] rx_byte;
  logic rx_valid;
  logic lp_err;
  modport lane (
    input lp_pin, hs_byte, hs_valid, force_hs,
    output term_en, rx_byte, rx_valid, lp_err
  );
  modport core (
    output lp_pin, hs_byte, hs_valid, force_hs,
    input term_en, rx_byte, rx_valid, lp_err
  );
endinterface : crx_lane_if

// file: hw/crx_lane.sv
// Low-power state tracker for one lane, on the link clock
`timescale 1ns/1ns
`include "crx_params.svh"
module crx_lane
  import crx_pkg::*;
(
  // Link clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Lane signals
  crx_lane_if.lane lane
);
  logic [1:0] lp_meta;
  logic [1:0] lp;
  crx_lane_e state;

  // Receive only: the lane pins are sampled, never driven
  always_ff @(posedge i_clk) begin
    lp_meta <= lane.lp_pin;
    lp <= lp_meta;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state <= LN_INIT;
    end else if (lane.force_hs) begin
      state <= LN_HS;
    end else begin
      case (state)
        LN_INIT: if (lp == `CRX_LP_STOP) state <= LN_STOP;
        LN_STOP: if (lp == `CRX_LP_HS_RQ) state <= LN_HS_RQ;
        LN_HS_RQ: begin
          if (lp == `CRX_LP_BRIDGE) begin
            state <= LN_HS;
          end else if (lp == `CRX_LP_STOP) begin
            state <= LN_STOP;
          end else if (lp != `CRX_LP_HS_RQ) begin
            // Escape entry is not decoded; wait for the next stop state
            state <= LN_INIT;
          end
        end
        LN_HS: if (lp == `CRX_LP_STOP) state <= LN_STOP;
        default: state <= LN_INIT;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      lane.term_en <= 1'h0;
      lane.rx_valid <= 1'h0;
      lane.rx_byte <= 8'h00;
      lane.lp_err <= 1'h0;
    end else begin
      lane.term_en <= (state == LN_HS);
      lane.rx_valid <= (state == LN_HS) && lane.hs_valid;
      lane.rx_byte <= lane.hs_byte;
      // LP-00 and LP-11 are both legal while the burst runs
      lane.lp_err <= (state == LN_HS) && !lane.force_hs &&
                     (lp != `CRX_LP_BRIDGE) && (lp != `CRX_LP_STOP);
    end
  end
endmodule : crx_lane

// file: hw/crx_receiver.sv
// Camera serial lane receiver with packet parser and error reporting
`timescale 1ns/1ns
`include "crx_params.svh"
module crx_receiver
  import crx_pkg::*;
#(
  parameter int LANES = 4
) (
  // Clocks and reset
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_lane_clk,
  // Lane pins, index 0 is the clock lane
  input wire logic [LANES:0] i_lp_p,
  input wire logic [LANES:0] i_lp_n,
  // High-speed bytes from the data lanes, link clock
  input wire logic [8*LANES-1:0] i_hs_byte,
  input wire logic [LANES-1:0] i_hs_valid,
  // Configuration
  input wire logic [2:0] i_lane_cnt,
  input wire logic i_cont_clk,
  input wire logic i_ecc_alarm_en,
  input wire logic i_crc_alarm_en,
  input wire logic i_status_clr,
  // Lane state
  output logic [LANES:0] o_term_en,
  output logic [LANES:0] o_lane_hs,
  // Packets
  output logic o_pkt_valid,
  output logic o_pkt_short,
  output logic [1:0] o_pkt_vc,
  output logic [5:0] o_pkt_dt,
  output logic [15:0] o_pkt_wc,
  output logic o_data_valid,
  output logic [7:0] o_data_byte,
  // Status
  output logic o_ecc_corr,
  output logic o_ecc_err,
  output logic o_crc_err,
  output logic o_len_change,
  output logic o_lp_err,
  output logic [7:0] o_err_count,
  // Alarms toward the control back link
  output logic o_alarm_ecc,
  output logic o_alarm_crc
);
  if (LANES != 1 && LANES != 2 && LANES != 4) begin : g_bad_lanes
    $error("crx_receiver: LANES must be 1, 2 or 4");
  end

  localparam logic [23:0] ECC_MASK [6] = '{
    `CRX_ECC_M0, `CRX_ECC_M1, `CRX_ECC_M2,
    `CRX_ECC_M3, `CRX_ECC_M4, `CRX_ECC_M5
  };

  function automatic logic [5:0] ecc_of(input logic [23:0] h);
    logic [5:0] p;
    p = '0;
    for (int k = 0; k < `CRX_ECC_BITS; k++) begin
      p[k] = ^(h & ECC_MASK[k]);
    end
    return p;
  endfunction : ecc_of

  function automatic logic [5:0] column_of(input int i);
    logic [5:0] c;
    c = '0;
    for (int k = 0; k < `CRX_ECC_BITS; k++) begin
      c[k] = ECC_MASK[k][i];
    end
    return c;
  endfunction : column_of

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int b = 0; b < 8; b++) begin
      if (r[0] ^ d[b]) begin
        r = (r >> 1) ^ `CRX_CRC_POLY;
      end else begin
        r = r >> 1;
      end
    end
    return r;
  endfunction : crc_step

  function automatic logic [2:0] lanes_used(input logic [2:0] req);
    if (req == 3'h4 && LANES >= 4) begin
      return 3'h4;
    end else if (req == 3'h2 && LANES >= 2) begin
      return 3'h2;
    end
    return 3'h1;
  endfunction : lanes_used

  // Link clock domain
  logic [1:0] lrst_sync;
  logic [1:0] cont_sync;
  logic [LANES:0] lane_valid;
  logic [LANES:0] lane_lperr;
  logic [8*LANES-1:0] rx_word;
  logic [8*LANES-1:0] word;
  logic word_tog;
  logic lperr_any;

  always_ff @(posedge i_lane_clk) begin
    lrst_sync <= {lrst_sync[0], i_rst};
    cont_sync <= {cont_sync[0], i_cont_clk};
  end

  crx_lane_if lanes [LANES+1] ();

  // Clock lane and data lanes share one tracker design
  for (genvar g = 0; g <= LANES; g++) begin : g_lane
    assign lanes[g].lp_pin = {i_lp_p[g], i_lp_n[g]};
    if (g == 0) begin : g_clk
      assign lanes[g].hs_byte = 8'h00;
      assign lanes[g].hs_valid = 1'h0;
      assign lanes[g].force_hs = cont_sync[1];
    end else begin : g_data
      assign lanes[g].hs_byte = i_hs_byte[8*(g-1) +: 8];
      assign lanes[g].hs_valid = i_hs_valid[g-1];
      assign lanes[g].force_hs = 1'h0;
      assign rx_word[8*(g-1) +: 8] = lanes[g].rx_byte;
    end
    assign lane_valid[g] = lanes[g].rx_valid;
    assign lane_lperr[g] = lanes[g].lp_err;
    assign o_term_en[g] = lanes[g].term_en;
    crx_lane u_lane (
      .i_clk(i_lane_clk),
      .i_rst(lrst_sync[1]),
      .lane(lanes[g])
    );
  end

  // One word per link cycle; the toggle marks it for the system clock
  always_ff @(posedge i_lane_clk) begin
    if (lrst_sync[1]) begin
      word <= '0;
      word_tog <= 1'h0;
      lperr_any <= 1'h0;
    end else begin
      lperr_any <= |lane_lperr;
      if (lane_valid[1]) begin
        word <= rx_word;
        word_tog <= ~word_tog;
      end
    end
  end

  // System clock domain: crossings
  logic [2:0] tog_sync;
  logic [LANES:0] hs_meta;
  logic [1:0] lperr_sync;
  logic burst_q;
  logic new_word;
  logic burst_end;

  always_ff @(posedge i_clk) begin
    tog_sync <= {tog_sync[1:0], word_tog};
    hs_meta <= o_term_en;
    o_lane_hs <= hs_meta;
    lperr_sync <= {lperr_sync[0], lperr_any};
    burst_q <= o_lane_hs[1];
  end

  assign new_word = tog_sync[2] ^ tog_sync[1];
  // Partial headers are dropped when the lane leaves high-speed
  assign burst_end = burst_q & ~o_lane_hs[1];

  // Byte pump: the word is stable for a whole link cycle after its toggle
  logic [31:0] wbuf;
  logic [2:0] left;
  logic [1:0] pos;
  logic bvalid;
  logic [7:0] bdata;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wbuf <= 32'h0000_0000;
      left <= 3'h0;
      pos <= 2'h0;
    end else if (new_word) begin
      wbuf <= 32'(word);
      left <= lanes_used(i_lane_cnt);
      pos <= 2'h0;
    end else if (left != 3'h0) begin
      left <= left - 3'h1;
      pos <= pos + 2'h1;
    end
  end

  assign bvalid = (left != 3'h0);
  assign bdata = wbuf[{pos, 3'h0} +: 8];

  // Header check
  crx_parse_e ps;
  logic [23:0] hdr;
  logic [1:0] hcnt;
  logic [15:0] remain;
  logic [15:0] crc;
  logic [7:0] crc_lo;
  logic [5:0] syndrome;
  logic [23:0] fixed_hdr;
  logic fixable;
  logic hdr_done;
  logic hdr_short;
  logic [15:0] hdr_wc;

  // Top two bits of the ECC byte carry no protection
  assign syndrome = ecc_of(hdr) ^ bdata[`CRX_ECC_BITS-1:0];

  always_comb begin
    fixed_hdr = hdr;
    fixable = (syndrome == 6'h00) || ($countones(syndrome) == 1);
    for (int i = 0; i < `CRX_HDR_BITS; i++) begin
      if (syndrome != 6'h00 && column_of(i) == syndrome) begin
        fixed_hdr[i] = ~hdr[i];
        fixable = 1'h1;
      end
    end
  end

  assign hdr_done = bvalid && (ps == PS_HDR) && (hcnt == `CRX_HDR_LAST);
  assign hdr_short = (fixed_hdr[`CRX_DT_MSB:0] <= `CRX_SHORT_DT_MAX);
  assign hdr_wc = fixed_hdr[`CRX_WC_MSB:`CRX_WC_LSB];

  // Packet sequencing
  always_ff @(posedge i_clk) begin
    if (i_rst || burst_end) begin
      ps <= PS_HDR;
      hcnt <= 2'h0;
      hdr <= 24'h00_0000;
      remain <= 16'h0000;
      crc <= `CRX_CRC_SEED;
      crc_lo <= 8'h00;
    end else if (bvalid) begin
      case (ps)
        PS_HDR: begin
          // Byte order: identifier, count low, count high, ECC
          hdr <= {bdata, hdr[23:8]};
          hcnt <= hcnt + 2'h1;
          if (hdr_done) begin
            crc <= `CRX_CRC_SEED;
            remain <= hdr_wc;
            if (!fixable) begin
              // Length unknown, so the rest of the burst is skipped
              ps <= PS_SKIP;
            end else if (hdr_short) begin
              ps <= PS_HDR;
            end else if (hdr_wc == 16'h0000) begin
              ps <= PS_CRC_LO;
            end else begin
              ps <= PS_DATA;
            end
          end
        end
        PS_DATA: begin
          crc <= crc_step(crc, bdata);
          remain <= remain - 16'h0001;
          if (remain == 16'h0001) begin
            ps <= PS_CRC_LO;
          end
        end
        PS_CRC_LO: begin
          crc_lo <= bdata;
          ps <= PS_CRC_HI;
        end
        PS_CRC_HI: begin
          ps <= PS_HDR;
        end
        default: begin
          ps <= PS_SKIP;
        end
      endcase
    end
  end

  // Packet and payload outputs
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_pkt_valid <= 1'h0;
      o_pkt_short <= 1'h0;
      o_pkt_vc <= 2'h0;
      o_pkt_dt <= 6'h00;
      o_pkt_wc <= 16'h0000;
      o_data_valid <= 1'h0;
      o_data_byte <= 8'h00;
    end else begin
      o_pkt_valid <= hdr_done && fixable;
      o_data_valid <= bvalid && (ps == PS_DATA);
      o_data_byte <= bdata;
      if (hdr_done && fixable) begin
        o_pkt_short <= hdr_short;
        o_pkt_vc <= fixed_hdr[`CRX_VC_MSB:`CRX_VC_LSB];
        o_pkt_dt <= fixed_hdr[`CRX_DT_MSB:0];
        o_pkt_wc <= hdr_wc;
      end
    end
  end

  // Error events
  logic ev_corr;
  logic ev_ecc2;
  logic ev_crc;
  logic ev_len;
  logic [15:0] last_wc;
  logic have_wc;

  assign ev_corr = hdr_done && fixable && (syndrome != 6'h00);
  assign ev_ecc2 = hdr_done && !fixable;
  assign ev_crc = bvalid && (ps == PS_CRC_HI) && ({bdata, crc_lo} != crc);
  assign ev_len = hdr_done && fixable && !hdr_short && have_wc && (hdr_wc != last_wc);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      last_wc <= 16'h0000;
      have_wc <= 1'h0;
    end else if (hdr_done && fixable && !hdr_short) begin
      last_wc <= hdr_wc;
      have_wc <= 1'h1;
    end
  end

  // Sticky status: a new event wins over a clear in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_ecc_corr <= 1'h0;
      o_ecc_err <= 1'h0;
      o_crc_err <= 1'h0;
      o_len_change <= 1'h0;
      o_lp_err <= 1'h0;
    end else begin
      o_ecc_corr <= ev_corr || (o_ecc_corr && !i_status_clr);
      o_ecc_err <= ev_ecc2 || (o_ecc_err && !i_status_clr);
      o_crc_err <= ev_crc || (o_crc_err && !i_status_clr);
      o_len_change <= ev_len || (o_len_change && !i_status_clr);
      o_lp_err <= lperr_sync[1] || (o_lp_err && !i_status_clr);
    end
  end

  // Saturating so a flood of errors cannot wrap to a small count
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_err_count <= 8'h00;
    end else if (ev_corr || ev_ecc2 || ev_crc) begin
      if (i_status_clr) begin
        o_err_count <= 8'h01;
      end else if (o_err_count != `CRX_ERR_CNT_MAX) begin
        o_err_count <= o_err_count + 8'h01;
      end
    end else if (i_status_clr) begin
      o_err_count <= 8'h00;
    end
  end

  // One-cycle alarms for the control back link
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_alarm_ecc <= 1'h0;
      o_alarm_crc <= 1'h0;
    end else begin
      o_alarm_ecc <= (ev_corr || ev_ecc2) && i_ecc_alarm_en;
      o_alarm_crc <= ev_crc && i_crc_alarm_en;
    end
  end
endmodule : crx_receiver

// file: testbench/crx_receiver_monitor.sv
// Port-level checks for the camera lane receiver
`timescale 1ns/1ns
module crx_receiver_monitor #(
  parameter int LANES = 4
) (
  // Clocks and reset
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_lane_clk,
  // Watched inputs
  input wire logic [LANES:0] i_lp_p,
  input wire logic [LANES:0] i_lp_n,
  input wire logic i_cont_clk,
  input wire logic i_ecc_alarm_en,
  input wire logic i_crc_alarm_en,
  input wire logic i_status_clr,
  // Watched outputs
  input wire logic [LANES:0] o_term_en,
  input wire logic o_pkt_valid,
  input wire logic o_pkt_short,
  input wire logic [5:0] o_pkt_dt,
  input wire logic o_ecc_corr,
  input wire logic o_ecc_err,
  input wire logic o_crc_err,
  input wire logic [7:0] o_err_count,
  input wire logic o_alarm_ecc,
  input wire logic o_alarm_crc
);
  wire logic [1:0] lp0 = {i_lp_p[0], i_lp_n[0]};
  wire logic [1:0] lp1 = {i_lp_p[1], i_lp_n[1]};
  property p_hs_entry;
    @(posedge i_lane_clk) disable iff (i_rst) $rose(o_term_en[1]) |-> $past(lp1, 2) == 2'b00;
  endproperty
  a_hs_entry: assert property (p_hs_entry) else $error("lane 1 hs without bridge");
  property p_hs_hold;
    @(posedge i_lane_clk) disable iff (i_rst) (lp1 == 2'b00) [*3] ##0 o_term_en[1] |=> o_term_en[1];
  endproperty
  a_hs_hold: assert property (p_hs_hold) else $error("lane 1 left hs early");
  property p_hs_exit;
    @(posedge i_lane_clk) disable iff (i_rst) (lp1 == 2'b11) [*6] |=> !o_term_en[1];
  endproperty
  a_hs_exit: assert property (p_hs_exit) else $error("lane 1 hs after stop");
  property p_clk_lane;
    @(posedge i_lane_clk) disable iff (i_rst) (lp0 == 2'b11 && !i_cont_clk) [*6] |=> !o_term_en[0];
  endproperty
  a_clk_lane: assert property (p_clk_lane) else $error("clock lane hs after stop");
  property p_cont;
    @(posedge i_lane_clk) disable iff (i_rst) i_cont_clk [*8] |=> o_term_en[0];
  endproperty
  a_cont: assert property (p_cont) else $error("clock lane not held hs");
  property p_short_cls;
    @(posedge i_clk) disable iff (i_rst) o_pkt_valid |-> o_pkt_short == (o_pkt_dt <= 6'h0f);
  endproperty
  a_short_cls: assert property (p_short_cls) else $error("short flag wrong");
  property p_ecc_alarm;
    @(posedge i_clk) disable iff (i_rst)
      o_alarm_ecc |-> $past(i_ecc_alarm_en) && (o_ecc_corr || o_ecc_err);
  endproperty
  a_ecc_alarm: assert property (p_ecc_alarm) else $error("ecc alarm wrong");
  property p_crc_alarm;
    @(posedge i_clk) disable iff (i_rst) o_alarm_crc |-> $past(i_crc_alarm_en) && o_crc_err;
  endproperty
  a_crc_alarm: assert property (p_crc_alarm) else $error("crc alarm wrong");
  property p_count;
    @(posedge i_clk) disable iff (i_rst) $rose(o_ecc_err) && !$past(i_status_clr) |->
      o_err_count == $past(o_err_count) + 8'h01 || $past(o_err_count) == 8'hff;
  endproperty
  a_count: assert property (p_count) else $error("error count not bumped");
  property p_sticky;
    @(posedge i_clk) disable iff (i_rst) o_crc_err && !i_status_clr |=> o_crc_err;
  endproperty
  a_sticky: assert property (p_sticky) else $error("crc status lost");
endmodule : crx_receiver_monitor

bind crx_receiver crx_receiver_monitor #(.LANES(LANES)) u_monitor (
  .i_clk, .i_rst, .i_lane_clk, .i_lp_p, .i_lp_n, .i_cont_clk, .i_ecc_alarm_en,
  .i_crc_alarm_en, .i_status_clr, .o_term_en, .o_pkt_valid, .o_pkt_short, .o_pkt_dt,
  .o_ecc_corr, .o_ecc_err, .o_crc_err, .o_err_count, .o_alarm_ecc, .o_alarm_crc
);

// file: testbench/crx_sensor_model.sv
// Behavioural image sensor driving lane levels and high-speed bytes
`timescale 1ns/1ns
module crx_sensor_model #(
  parameter int LANES = 2
) (
  // Link clock
  input wire logic i_lane_clk,
  // Lanes toward the receiver, forward only
  output logic [LANES:0] o_lp_p,
  output logic [LANES:0] o_lp_n,
  output logic [8*LANES-1:0] o_hs_byte,
  output logic [LANES-1:0] o_hs_valid
);
  initial begin
    o_lp_p = '1;
    o_lp_n = '1;
    o_hs_byte = '0;
    o_hs_valid = '0;
  end
  // Idle bytes keep toggling so stale data never looks valid
  task automatic hold(input logic [1:0] lv, input int n);
    repeat (n) begin
      @(posedge i_lane_clk);
      #1;
      o_lp_p <= {(LANES+1){lv[1]}};
      o_lp_n <= {(LANES+1){lv[0]}};
      o_hs_byte <= ~o_hs_byte;
      o_hs_valid <= '0;
    end
  endtask : hold
  task automatic send(input bit esc, input bit glitch, input int nl, input logic [7:0] q [$]);
    hold(2'b11, 4);
    hold(2'b01, 4);
    hold(esc ? 2'b10 : 2'b00, 7);
    while (q.size() > 0) begin
      @(posedge i_lane_clk);
      #1;
      // Lanes past the active count carry filler only
      for (int k = 0; k < LANES; k++) begin
        o_hs_byte[8*k+:8] <= (k < nl && q.size() > 0) ? q.pop_front() : 8'h00;
      end
      o_hs_valid <= '1;
    end
    // A glitch leaves LP-00 while the lane is still high-speed
    hold(glitch ? 2'b01 : 2'b00, 1);
    hold(2'b11, 6);
  endtask : send
endmodule : crx_sensor_model

// file: testbench/test_crx_receiver.sv
// Self-checking bench for the camera lane receiver and packet parser
`timescale 1ns/1ns
`include "crx_params.svh"
module test_crx_receiver;
  localparam int LANES = 2;
  localparam logic [23:0] MASK [6] = '{`CRX_ECC_M0, `CRX_ECC_M1, `CRX_ECC_M2,
                                      `CRX_ECC_M3, `CRX_ECC_M4, `CRX_ECC_M5};
  logic i_clk = 0;
  logic i_lane_clk = 0;
  logic i_rst = 1;
  logic cont = 0;
  logic ecc_en = 1;
  logic crc_en = 0;
  logic clr = 0;
  logic [2:0] lane_cnt = 3'h2;
  bit glitch = 0;
  logic [LANES:0] lp_p, lp_n, term_en, lane_hs;
  logic [8*LANES-1:0] hs_byte;
  logic [LANES-1:0] hs_valid;
  logic pv, ps, dv, corr, uncorr, crc_err, len_chg, lp_err, a_ecc, a_crc;
  logic [1:0] vc;
  logic [5:0] dt;
  logic [15:0] wc;
  logic [7:0] db, cnt;
  int error_cnt = 0;
  int n_compared = 0;
  int n_aecc = 0;
  int n_acrc = 0;
  logic [24:0] exp_pkt [$];
  logic [7:0] exp_data [$];
  logic [7:0] stream [$];
  initial forever #10 i_clk = ~i_clk;
  initial begin
    #7;
    forever #80 i_lane_clk = ~i_lane_clk;
  end
  crx_receiver #(.LANES(LANES)) dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_lane_clk(i_lane_clk), .i_lp_p(lp_p), .i_lp_n(lp_n),
    .i_hs_byte(hs_byte), .i_hs_valid(hs_valid), .i_lane_cnt(lane_cnt), .i_cont_clk(cont),
    .i_ecc_alarm_en(ecc_en), .i_crc_alarm_en(crc_en), .i_status_clr(clr),
    .o_term_en(term_en), .o_lane_hs(lane_hs), .o_pkt_valid(pv), .o_pkt_short(ps),
    .o_pkt_vc(vc), .o_pkt_dt(dt), .o_pkt_wc(wc), .o_data_valid(dv), .o_data_byte(db),
    .o_ecc_corr(corr), .o_ecc_err(uncorr), .o_crc_err(crc_err), .o_len_change(len_chg),
    .o_lp_err(lp_err), .o_err_count(cnt), .o_alarm_ecc(a_ecc), .o_alarm_crc(a_crc)
  );
  crx_sensor_model #(.LANES(LANES)) sensor (
    .i_lane_clk(i_lane_clk), .o_lp_p(lp_p), .o_lp_n(lp_n), .o_hs_byte(hs_byte),
    .o_hs_valid(hs_valid)
  );
  task automatic chk_pkt(input string nm, input logic [24:0] e, input logic [24:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_pkt
  task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_val
  function automatic logic [7:0] ecc_of(input logic [23:0] h);
    logic [7:0] e;
    e = 8'h00;
    for (int k = 0; k < 6; k++) e[k] = ^(h & MASK[k]);
    return e;
  endfunction : ecc_of
  // Header bytes, then payload and footer for long types; flip corrupts the wire copy
  task automatic pkt(input logic [1:0] v, input logic [5:0] t, input logic [15:0] n,
                     input logic [23:0] flip, input logic [15:0] cflip);
    logic [23:0] h;
    logic [15:0] c;
    logic [7:0] b;
    h = {n, v, t};
    c = `CRX_CRC_SEED;
    if ($countones(flip) < 2) exp_pkt.push_back({t <= `CRX_SHORT_DT_MAX, v, t, n});
    stream.push_back(h[7:0] ^ flip[7:0]);
    stream.push_back(h[15:8] ^ flip[15:8]);
    stream.push_back(h[23:16] ^ flip[23:16]);
    stream.push_back(ecc_of(h));
    if (t > `CRX_SHORT_DT_MAX) begin
      repeat (n) begin
        b = 8'($urandom);
        stream.push_back(b);
        if ($countones(flip) < 2) exp_data.push_back(b);
        for (int i = 0; i < 8; i++) c = (c >> 1) ^ ((c[0] ^ b[i]) ? `CRX_CRC_POLY : 16'h0000);
      end
      c = c ^ cflip;
      stream.push_back(c[7:0]);
      stream.push_back(c[15:8]);
    end
  endtask : pkt
  task automatic burst(input bit esc);
    sensor.send(esc, glitch, int'(lane_cnt), stream);
    stream.delete();
    repeat (20) @(posedge i_clk);
  endtask : burst
  always @(posedge i_clk) begin
    if (pv === 1'b1) chk_pkt("pkt", exp_pkt.size() ? exp_pkt.pop_front() : 'x, {ps, vc, dt, wc});
    if (dv === 1'b1) chk_val("byte", exp_data.size() ? exp_data.pop_front() : 'x, db);
    if (a_ecc === 1'b1) n_aecc++;
    if (a_crc === 1'b1) n_acrc++;
  end
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done
  initial begin
    #400_000;
    error_cnt++;
    test_done();
  end
  initial begin
    void'($urandom(32'h5e0e_322a));
    // Link domain resets from a synced copy, so hold across several link edges
    repeat (32) @(posedge i_clk);
    #1 i_rst = 0;
    pkt(2'($urandom), 6'($urandom_range(15)), 16'($urandom), 0, 0);
    pkt(2'($urandom), 6'h2a, 16'(1 + $urandom_range(5)), 0, 0);
    pkt(2'($urandom), `CRX_SHORT_DT_MAX, 16'($urandom), 0, 0);
    pkt(2'($urandom), 6'h10, 16'h0000, 0, 0);
    burst(0);
    chk_val("status", 5'b00010, {corr, uncorr, crc_err, len_chg, lp_err});
    chk_val("lane_hs", 0, lane_hs);
    pkt(2'($urandom), 6'h24, 16'h0003, 24'h00_0001 << $urandom_range(23), 0);
    pkt(2'($urandom), 6'h2b, 16'h0004, 0, 16'h0100);
    burst(0);
    chk_val("status", 5'b10110, {corr, uncorr, crc_err, len_chg, lp_err});
    chk_val("alarms", 24'h02_0100, {cnt, 8'(n_aecc), 8'(n_acrc)});
    @(posedge i_clk);
    #1 ecc_en = 0;
    crc_en = 1;
    pkt(2'($urandom), 6'h30, 16'h0002, 0, 16'h8000);
    pkt(2'($urandom), 6'h2a, 16'h0002, 24'h00_0011, 0);
    burst(0);
    chk_val("status", 5'b11110, {corr, uncorr, crc_err, len_chg, lp_err});
    chk_val("alarms", 24'h04_0101, {cnt, 8'(n_aecc), 8'(n_acrc)});
    // Single active lane, and a burst that leaves LP-00 before its stop state
    @(posedge i_clk);
    #1 lane_cnt = 3'h1;
    glitch = 1;
    pkt(2'($urandom), 6'h12, 16'h0003, 0, 0);
    burst(0);
    chk_val("status", 5'h1f, {corr, uncorr, crc_err, len_chg, lp_err});
    chk_val("alarms", 24'h04_0101, {cnt, 8'(n_aecc), 8'(n_acrc)});
    @(posedge i_clk);
    #1 lane_cnt = 3'h2;
    glitch = 0;
    @(posedge i_clk);
    #1 clr = 1;
    @(posedge i_clk);
    #1 clr = 0;
    repeat (2) @(posedge i_clk);
    chk_val("cleared", 0, {corr, uncorr, crc_err, len_chg, lp_err, cnt});
    pkt(2'($urandom), 6'h01, 16'($urandom), 0, 0);
    exp_pkt.delete();
    burst(1);
    @(posedge i_clk);
    #1 cont = 1;
    pkt(2'($urandom), 6'h02, 16'($urandom), 0, 0);
    burst(0);
    chk_val("lane_hs", 3'b001, lane_hs);
    chk_val("left", 0, exp_pkt.size() + exp_data.size());
    test_done();
  end
endmodule : test_crx_receiver
